/* File: common/vram_port_regs.vh */
/*
  timing and field constants for the random-port host controller of a
  64K x 4 dual-port video dram.
  assumes a 250 MHz host clock; all device pins are asynchronous to it.
*/
// How it works
// - controller drives write-enable low for write, high for read.
// - delayed write lowers write-enable after column fall; rmw reads then writes.
// - page mode keeps row strobe low and cycles column strobe.
// - controller refreshes all 256 rows within every 4 ms unless a page is held open; refresh starts only from idle.
// - row-only refresh strobes row addresses with column strobe high.
`ifndef VRAM_PORT_REGS_VH
`define VRAM_PORT_REGS_VH
`define CLK_PERIOD_NS 4
// generic phase length in ns (row/column setup, hold, access)
`define PHASE_NS 40
`define PHASE_CYC ((`PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_WINDOW_NS 4000000
`define REFRESH_ROWS 256
// longest spacing, rounded down
`define REFRESH_GAP_CYC ((`REFRESH_WINDOW_NS / `REFRESH_ROWS) / `CLK_PERIOD_NS)
`define OP_READ 3'h0
`define OP_EARLY_WR 3'h1
`define OP_DELAYED_WR 3'h2
`define OP_RMW 3'h3
`define OP_ROW_REFRESH 3'h4
`define OP_CBR_REFRESH 3'h5
`define OP_TRANSFER 3'h6
`define OP_HIDDEN_REFRESH 3'h7
`endif

/* File: rtl/phase_timer.v */
/*
  phase timer: one-cycle enable pulse every PHASE_CYC cycles while running.
  assumes the same clock and reset as the controller.
*/
`include "vram_port_regs.vh"
module phase_timer (
  input wire i_clk,
  input wire i_rstn,
  input wire i_run,
  output wire o_tick
);
  reg [7:0] cnt_r;
  localparam [31:0] LAST_FULL = `PHASE_CYC - 1;
  wire [7:0] last = LAST_FULL[7:0];
  assign o_tick = i_run && (cnt_r == last);
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 8'h00;
    end else if (!i_run || o_tick) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // phase_timer

/* File: rtl/vram_port_host.v */
/*
  host controller for the random port of a dual-port video dram.
  takes one request at a time, sequences the strobes, and inserts
  periodic refresh. assumes the device pins are wired directly and the
  bench resolves the data pins from O_MASK_DATA_OE.
*/
`include "vram_port_regs.vh"
module vram_port_host #(
  parameter REFRESH_GAP = `REFRESH_GAP_CYC
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire I_REQ_VALID,
  input wire [2:0] I_REQ_OP,
  input wire [7:0] I_REQ_ROW,
  input wire [7:0] I_REQ_COL,
  input wire [3:0] I_REQ_WDATA,
  input wire I_REQ_MASK_EN,
  input wire [3:0] I_REQ_MASK,
  input wire I_REQ_PAGE_LAST,
  output wire O_REQ_READY,
  output reg O_RDATA_VALID,
  output reg [3:0] O_RDATA,
  output reg O_RAS_N,
  output reg O_CAS_N,
  output reg O_MASK_WRITE_SELECT_N,
  output reg O_TRANSFER_OUTPUT_ENABLE_N,
  output reg [7:0] O_MUXED_ADDRESS,
  output reg [3:0] O_MASK_DATA_OUT,
  output reg O_MASK_DATA_OE,
  input wire [3:0] I_MASK_DATA_IN
);
  // ==========================================================
  // states
  localparam S_IDLE = 4'h0;
  localparam S_ROW = 4'h1;
  localparam S_COL = 4'h2;
  localparam S_DATA = 4'h3;
  localparam S_WR = 4'h4;
  localparam S_CASUP = 4'h5;
  localparam S_PAGE = 4'h6;
  localparam S_PRE = 4'h7;
  localparam S_CBR = 4'h8;
  localparam S_HIDE = 4'h9;

  reg [3:0] st_r, st_nxt;
  reg [2:0] op_r;
  reg [7:0] col_r;
  reg [3:0] wd_r;
  reg last_r;
  reg [31:0] ref_cnt_r;
  reg ref_due_r;
  reg [3:0] dq_s1_r, dq_s2_r, dq_s3_r;
  wire tick;

  phase_timer u_timer (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_run(st_r != S_IDLE),
    .o_tick(tick)
  );

  function is_write;
    input [2:0] op;
    begin
      is_write = (op == `OP_EARLY_WR) || (op == `OP_DELAYED_WR) || (op == `OP_RMW);
    end
  endfunction

  // ==========================================================
  // refresh scheduler
  // one refresh per gap covers 256 rows in 4 ms
  always @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ref_cnt_r <= 32'h0;
      ref_due_r <= 1'b0;
    end else begin
      if (ref_cnt_r >= REFRESH_GAP - 1) begin
        ref_cnt_r <= 32'h0;
      end else begin
        ref_cnt_r <= ref_cnt_r + 32'h1;
      end
      // set wins over clear
      if (ref_cnt_r >= REFRESH_GAP - 1) begin
        ref_due_r <= 1'b1;
      end else if (st_r == S_CBR && tick) begin
        ref_due_r <= 1'b0;
      end
    end
  end

  assign O_REQ_READY = (st_r == S_IDLE) && !ref_due_r;

  // ==========================================================
  // pin synchroniser: second and third stage must agree
  always @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      dq_s1_r <= 4'h0;
      dq_s2_r <= 4'h0;
      dq_s3_r <= 4'h0;
    end else begin
      dq_s1_r <= I_MASK_DATA_IN;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  // ==========================================================
  // sequencer
  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (ref_due_r) begin
          st_nxt = S_CBR;
        end else if (I_REQ_VALID) begin
          st_nxt = S_ROW;
        end
      end
      S_ROW: if (tick) begin
        if (op_r == `OP_ROW_REFRESH || op_r == `OP_TRANSFER) st_nxt = S_PRE;
        else if (op_r == `OP_CBR_REFRESH) st_nxt = S_CBR;
        else st_nxt = S_COL;
      end
      S_COL: if (tick) st_nxt = S_DATA;
      S_DATA: if (tick) begin
        if (op_r == `OP_DELAYED_WR || op_r == `OP_RMW) st_nxt = S_WR;
        else if (op_r == `OP_HIDDEN_REFRESH) st_nxt = S_HIDE;
        else st_nxt = S_CASUP;
      end
      S_WR: if (tick) st_nxt = S_CASUP;
      S_CASUP: if (tick) st_nxt = last_r ? S_PRE : S_PAGE;
      S_PAGE: if (I_REQ_VALID) st_nxt = S_COL;
      S_PRE: if (tick) st_nxt = S_IDLE;
      S_HIDE: if (tick) st_nxt = S_CBR;
      S_CBR: if (tick) st_nxt = S_PRE;
      default: st_nxt = S_IDLE;
    endcase
  end

  always @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r <= S_IDLE;
      op_r <= `OP_READ;
      col_r <= 8'h00;
      wd_r <= 4'h0;
      last_r <= 1'b1;
      O_RAS_N <= 1'b1;
      O_CAS_N <= 1'b1;
      O_MASK_WRITE_SELECT_N <= 1'b1;
      O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
      O_MUXED_ADDRESS <= 8'h00;
      O_MASK_DATA_OUT <= 4'h0;
      O_MASK_DATA_OE <= 1'b0;
      O_RDATA_VALID <= 1'b0;
      O_RDATA <= 4'h0;
    end else begin
      st_r <= st_nxt;
      O_RDATA_VALID <= 1'b0;
      case (st_r)
        S_IDLE: begin
          O_RAS_N <= 1'b1;
          O_CAS_N <= 1'b1;
          O_MASK_DATA_OE <= 1'b0;
          if (ref_due_r) begin
            // column low before row fall, counter row used
            op_r <= `OP_CBR_REFRESH;
            O_CAS_N <= 1'b0;
          end else if (I_REQ_VALID) begin
            op_r <= I_REQ_OP;
            col_r <= I_REQ_COL;
            wd_r <= I_REQ_WDATA;
            last_r <= I_REQ_PAGE_LAST;
            // row address set up before row strobe falls
            O_MUXED_ADDRESS <= I_REQ_ROW;
            O_TRANSFER_OUTPUT_ENABLE_N <= (I_REQ_OP == `OP_TRANSFER) ? 1'b0 : 1'b1;
            // write-enable low at row fall enables masking
            O_MASK_WRITE_SELECT_N <= !(is_write(I_REQ_OP) && I_REQ_MASK_EN);
            // mask bits presented at row fall
            O_MASK_DATA_OUT <= I_REQ_MASK;
            O_MASK_DATA_OE <= is_write(I_REQ_OP) && I_REQ_MASK_EN;
            // requested refresh lowers column before row
            O_CAS_N <= (I_REQ_OP == `OP_CBR_REFRESH) ? 1'b0 : 1'b1;
          end
        end
        S_ROW: begin
          O_RAS_N <= 1'b0;
          if (tick) begin
            O_MASK_DATA_OE <= 1'b0;
            O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
            O_MUXED_ADDRESS <= col_r;
            // early write has write-enable low before column fall
            O_MASK_WRITE_SELECT_N <= (op_r == `OP_EARLY_WR) ? 1'b0 : 1'b1;
            if (op_r == `OP_EARLY_WR) begin
              O_MASK_DATA_OUT <= wd_r;
              O_MASK_DATA_OE <= 1'b1;
            end
          end
        end
        S_COL: begin
          // column strobe cycles inside open row
          // row plus column picks one nibble
          O_CAS_N <= 1'b0;
          if (tick) begin
            // output enable low for every op code except early write and delayed write
            // early write keeps output enable high
            if (!is_write(op_r) || op_r == `OP_RMW) begin
              O_TRANSFER_OUTPUT_ENABLE_N <= 1'b0;
            end
          end
        end
        S_DATA: begin
          if (tick) begin
            // sample while column strobe is low
            // read data only from read phases
            if (!is_write(op_r) || op_r == `OP_RMW) begin
              O_RDATA <= (dq_s2_r == dq_s3_r) ? dq_s3_r : O_RDATA;
              O_RDATA_VALID <= 1'b1;
            end
            // late write-enable, output enable back high first
            if (op_r == `OP_DELAYED_WR || op_r == `OP_RMW) begin
              O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
              O_MASK_DATA_OUT <= wd_r;
              // controller alone drives data in write phase
              O_MASK_DATA_OE <= 1'b1;
            end
          end
        end
        S_WR: begin
          // write strobe falls after data settles
          O_MASK_WRITE_SELECT_N <= 1'b0;
        end
        S_CASUP: begin
          O_CAS_N <= 1'b1;
          O_MASK_DATA_OE <= 1'b0;
          O_MASK_WRITE_SELECT_N <= 1'b1;
          O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
        end
        S_PAGE: begin
          if (I_REQ_VALID) begin
            col_r <= I_REQ_COL;
            wd_r <= I_REQ_WDATA;
            op_r <= I_REQ_OP;
            last_r <= I_REQ_PAGE_LAST;
            O_MUXED_ADDRESS <= I_REQ_COL;
            O_MASK_WRITE_SELECT_N <= (I_REQ_OP == `OP_EARLY_WR) ? 1'b0 : 1'b1;
            O_MASK_DATA_OUT <= I_REQ_WDATA;
            O_MASK_DATA_OE <= (I_REQ_OP == `OP_EARLY_WR);
          end
        end
        S_HIDE: begin
          // column held low, row strobe cycled
          O_RAS_N <= 1'b1;
          O_TRANSFER_OUTPUT_ENABLE_N <= 1'b0;
          // output-enable high before row fall, else a transfer starts
          if (tick) begin
            O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
          end
        end
        S_CBR: begin
          O_RAS_N <= 1'b0;
          O_MASK_DATA_OE <= 1'b0;
          if (tick) begin
            O_CAS_N <= 1'b1;
            O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
          end
        end
        S_PRE: begin
          O_RAS_N <= 1'b1;
          O_CAS_N <= 1'b1;
          O_MASK_DATA_OE <= 1'b0;
          O_TRANSFER_OUTPUT_ENABLE_N <= 1'b1;
          O_MASK_WRITE_SELECT_N <= 1'b1;
        end
        default: ;
      endcase
    end
  end
endmodule // vram_port_host

/* File: verification/vram_port_monitor.sv */
/* assertion checker for vram_port_host, bound at the foot of this file.
   assumes one clock and an async active-low reset. */
module vram_port_monitor #(
  parameter int REFRESH_GAP = 200
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire O_REQ_READY,
  input wire O_RDATA_VALID,
  input wire O_RAS_N,
  input wire O_CAS_N,
  input wire O_MASK_WRITE_SELECT_N,
  input wire O_TRANSFER_OUTPUT_ENABLE_N,
  input wire [7:0] O_MUXED_ADDRESS,
  input wire O_MASK_DATA_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // ==========================================
  // refresh spacing, restarted by each column-before-row refresh
  logic [15:0] gap_r;
  logic ras_d_r;
  always @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      gap_r <= 16'h0000;
      ras_d_r <= 1'b1;
    end else begin
      ras_d_r <= O_RAS_N;
      if (ras_d_r && !O_RAS_N && !O_CAS_N) gap_r <= 16'h0000;
      else gap_r <= gap_r + 16'h0001;
    end
  end
  // ==========================================
  // strobe and data pin relations
  a_row_addr_setup: assert property ($fell(O_RAS_N) |-> $stable(O_MUXED_ADDRESS))
    else $error("row address moved at row strobe");
  a_col_addr_setup: assert property ($fell(O_CAS_N) && !O_RAS_N |-> $stable(O_MUXED_ADDRESS))
    else $error("column address moved at column strobe");
  a_idle_standby: assert property (O_REQ_READY |-> O_RAS_N && O_CAS_N && !O_MASK_DATA_OE)
    else $error("strobes active while idle");
  a_read_phase_clean: assert property ($fell(O_TRANSFER_OUTPUT_ENABLE_N) && !O_RAS_N
    |-> (O_MASK_WRITE_SELECT_N && !O_MASK_DATA_OE) [*3]) else $error("read phase not clean");
  a_early_wr_data: assert property ($fell(O_CAS_N) && !O_RAS_N && !O_MASK_WRITE_SELECT_N
    |-> O_MASK_DATA_OE) else $error("early write without data");
  a_mask_at_row: assert property ($fell(O_RAS_N) && O_TRANSFER_OUTPUT_ENABLE_N
    && !O_MASK_WRITE_SELECT_N |-> O_MASK_DATA_OE) else $error("mask bits not driven");
  a_cbr_setup: assert property ($fell(O_RAS_N) && !O_CAS_N |-> !$past(O_CAS_N) && !O_MASK_DATA_OE)
    else $error("refresh column setup broken");
  a_oe_after_row: assert property ($fell(O_TRANSFER_OUTPUT_ENABLE_N) && !O_CAS_N
    |-> !O_RAS_N && !$past(O_RAS_N, 2)) else $error("output enable before hold");
  a_drive_oe_high: assert property (O_MASK_DATA_OE && !O_RAS_N |-> O_TRANSFER_OUTPUT_ENABLE_N)
    else $error("bus clash on data pins");
  a_refresh_gap: assert property (gap_r <= 16'(REFRESH_GAP + 300))
    else $error("refresh interval exceeded");
  a_cbr_no_transfer: assert property ($fell(O_RAS_N) && !O_CAS_N |-> O_TRANSFER_OUTPUT_ENABLE_N)
    else $error("refresh row fall with output enable low");
  a_late_wr_setup: assert property ($fell(O_MASK_WRITE_SELECT_N) && !O_CAS_N
    |-> O_MASK_DATA_OE && $past(O_MASK_DATA_OE)) else $error("late write data not set up");
  c_read_done: cover property (O_RDATA_VALID);
  c_cbr: cover property ($fell(O_RAS_N) && !O_CAS_N);
  c_masked: cover property ($fell(O_RAS_N) && !O_MASK_WRITE_SELECT_N);
endmodule // vram_port_monitor
bind vram_port_host vram_port_monitor #(.REFRESH_GAP(REFRESH_GAP)) i_vram_port_monitor (.I_CLK(I_CLK),
  .I_RSTN(I_RSTN), .O_REQ_READY(O_REQ_READY), .O_RDATA_VALID(O_RDATA_VALID), .O_RAS_N(O_RAS_N),
  .O_CAS_N(O_CAS_N), .O_MASK_WRITE_SELECT_N(O_MASK_WRITE_SELECT_N),
  .O_TRANSFER_OUTPUT_ENABLE_N(O_TRANSFER_OUTPUT_ENABLE_N), .O_MUXED_ADDRESS(O_MUXED_ADDRESS),
  .O_MASK_DATA_OE(O_MASK_DATA_OE));

/* File: verification/vram_dev_model.sv */
/* behavioural model of the random port of a 64K x 4 video dram.
   assumes the bench resolves the shared data pins and feeds them to dq. */
module vram_dev_model #(
  parameter int ACC_NS = 12
) (
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire oe_n,
  input wire [7:0] addr,
  input wire [3:0] dq,
  output logic [3:0] q,
  output logic q_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mem [0:65535];
  logic [3:0] wmask, qv;
  logic [7:0] row, rcnt;
  logic [15:0] a;
  logic xfer, rdok;
  initial begin
    foreach (mem[i]) mem[i] = 4'h0;
    {wmask, qv, row, rcnt, a, xfer, rdok} = '0;
  end
  // ==========================================
  // strobe decoding
  // row strobe fall
  always @(negedge ras_n) begin
    row = addr;
    xfer = !oe_n;
    wmask = we_n ? 4'hF : dq;
    if (cas_n) rdok = 1'b0;
    else rcnt = rcnt + 8'h01;
  end
  always @(negedge cas_n)
    if (!ras_n) begin
      a = {row, addr};
      qv = mem[a];
      rdok = we_n && !xfer;
      if (!we_n && !xfer) mem[a] = (mem[a] & ~wmask) | (dq & wmask);
    end
  always @(negedge we_n)
    if (!ras_n && !cas_n && !xfer) begin
      rdok = 1'b0;
      mem[a] = (mem[a] & ~wmask) | (dq & wmask);
    end
  // ==========================================
  // output buffers
  assign q_oe = rdok && !cas_n && !oe_n;
  // released pins show the inverse, so a stale value can never pass
  assign #(ACC_NS) q = q_oe ? qv : ~qv;
endmodule // vram_dev_model

/* File: verification/vram_port_host_tb.sv */
/* self-checking bench for vram_port_host with a device model.
   assumes the shared data pins are resolved here from O_MASK_DATA_OE alone. */
`include "vram_port_regs.vh"
module vram_port_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP = 200;
  logic I_CLK, I_RSTN, I_REQ_VALID, I_REQ_MASK_EN, I_REQ_PAGE_LAST;
  logic [2:0] I_REQ_OP;
  logic [7:0] I_REQ_ROW, I_REQ_COL;
  logic [3:0] I_REQ_WDATA, I_REQ_MASK, I_MASK_DATA_IN, dev_q;
  wire O_REQ_READY, O_RDATA_VALID, O_RAS_N, O_CAS_N, O_MASK_WRITE_SELECT_N;
  wire O_TRANSFER_OUTPUT_ENABLE_N, O_MASK_DATA_OE, dev_oe;
  wire [3:0] O_RDATA, O_MASK_DATA_OUT;
  wire [7:0] O_MUXED_ADDRESS;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] lfsr = 32'h66AD;
  logic [3:0] shm [0:65535] = '{default: 4'h0};
  logic [3:0] expq [$];
  vram_port_host #(.REFRESH_GAP(GAP)) i_vram_port_host (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_REQ_VALID(I_REQ_VALID),
    .I_REQ_OP(I_REQ_OP), .I_REQ_ROW(I_REQ_ROW), .I_REQ_COL(I_REQ_COL), .I_REQ_WDATA(I_REQ_WDATA),
    .I_REQ_MASK_EN(I_REQ_MASK_EN), .I_REQ_MASK(I_REQ_MASK), .I_REQ_PAGE_LAST(I_REQ_PAGE_LAST),
    .O_REQ_READY(O_REQ_READY), .O_RDATA_VALID(O_RDATA_VALID), .O_RDATA(O_RDATA), .O_RAS_N(O_RAS_N),
    .O_CAS_N(O_CAS_N), .O_MASK_WRITE_SELECT_N(O_MASK_WRITE_SELECT_N),
    .O_TRANSFER_OUTPUT_ENABLE_N(O_TRANSFER_OUTPUT_ENABLE_N), .O_MUXED_ADDRESS(O_MUXED_ADDRESS),
    .O_MASK_DATA_OUT(O_MASK_DATA_OUT), .O_MASK_DATA_OE(O_MASK_DATA_OE), .I_MASK_DATA_IN(I_MASK_DATA_IN));
  vram_dev_model i_vram_dev_model (.ras_n(O_RAS_N), .cas_n(O_CAS_N), .we_n(O_MASK_WRITE_SELECT_N),
    .oe_n(O_TRANSFER_OUTPUT_ENABLE_N), .addr(O_MUXED_ADDRESS), .dq(I_MASK_DATA_IN), .q(dev_q), .q_oe(dev_oe));
  assign I_MASK_DATA_IN = O_MASK_DATA_OE ? O_MASK_DATA_OUT : dev_q;
  initial begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // k: 0 ready, 1 column strobe low, 2 column strobe high
  task automatic waitc(input int k);
    int n;
    n = 0;
    while (!((k == 0 && O_REQ_READY === 1'b1) || (k == 1 && O_CAS_N === 1'b0) || (k == 2 && O_CAS_N === 1'b1))
           && n < 3000) begin
      @(negedge I_CLK);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      finish_test();
    end
  endtask
  // page follow-ups have no ready, so the take is seen at the column strobe
  task automatic req(input logic [2:0] op, input logic [7:0] r, c, input logic [3:0] wd, m,
                     input logic me, last, pg);
    logic [3:0] wm;
    wm = me ? m : 4'hF;
    @(negedge I_CLK);
    {I_REQ_OP, I_REQ_ROW, I_REQ_COL, I_REQ_WDATA, I_REQ_MASK, I_REQ_MASK_EN, I_REQ_PAGE_LAST} = {op, r, c, wd, m, me, last};
    I_REQ_VALID = 1'b1;
    if (pg) begin
      waitc(1);
      waitc(2);
      waitc(1);
    end else begin
      waitc(0);
      @(negedge I_CLK);
    end
    I_REQ_VALID = 1'b0;
    if (op inside {`OP_READ, `OP_RMW, `OP_HIDDEN_REFRESH}) expq.push_back(shm[{r, c}]);
    if (op inside {`OP_EARLY_WR, `OP_DELAYED_WR, `OP_RMW}) shm[{r, c}] = (shm[{r, c}] & ~wm) | (wd & wm);
  endtask
  // ==========================================
  // result watcher
  always @(negedge I_CLK) begin
    if (O_RDATA_VALID === 1'b1) begin
      if (expq.size() == 0) chk("unasked read", 4'h0, 4'hF);
      else chk("read data", expq.pop_front(), O_RDATA);
    end
    if (O_MASK_DATA_OE === 1'b1 && dev_oe === 1'b1) chk("data pin drivers", 4'h1, 4'h2);
  end
  // ==========================================
  // main sequence
  initial begin
    {I_REQ_VALID, I_REQ_OP, I_REQ_ROW, I_REQ_COL, I_REQ_WDATA, I_REQ_MASK, I_REQ_MASK_EN, I_REQ_PAGE_LAST} = '0;
    I_RSTN = 1'b0;
    repeat (8) @(negedge I_CLK);
    chk("reset strobes", 4'hF, {O_RAS_N, O_CAS_N, O_MASK_WRITE_SELECT_N, O_TRANSFER_OUTPUT_ENABLE_N});
    I_RSTN = 1'b1;
    // every op code against corner addresses, random data and masks
    for (int i = 0; i < 48; i++) begin
      lfsr = nxt(lfsr);
      req(i[2:0], {8{lfsr[0]}}, {8{lfsr[1]}}, lfsr[7:4], lfsr[11:8],
          lfsr[12] && i[2:0] inside {3'h1, 3'h2, 3'h3}, 1'b1, 1'b0);
    end
    req(`OP_EARLY_WR, 8'h5A, 8'h00, 4'hA, 4'h0, 1'b0, 1'b0, 1'b0);
    req(`OP_DELAYED_WR, 8'h5A, 8'hFF, 4'h5, 4'h0, 1'b0, 1'b0, 1'b1);
    req(`OP_READ, 8'h5A, 8'h00, 4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
    req(`OP_READ, 8'h5A, 8'hFF, 4'h0, 4'h0, 1'b0, 1'b1, 1'b1);
    repeat (GAP * 3) @(negedge I_CLK);
    waitc(0);
    chk("reads left", 4'h0, 4'(expq.size()));
    chk("idle strobes", 4'hF, {O_RAS_N, O_CAS_N, O_MASK_WRITE_SELECT_N, O_TRANSFER_OUTPUT_ENABLE_N});
    finish_test();
  end
endmodule // vram_port_host_tb
